// ===== verilog/cap_sense_pkg.sv
// Constants and types shared by the capacitive sense oscillator control logic
// Overview of operation
// [RULE1] Reference mode 1 picks converter/fixed-reference thresholds; 0 picks ground and supply.
// [RULE2] Fixed mode: range 00 off, 01 low, 10 medium, 11 high current.
// [RULE3] Variable mode: range 00 is noise detection with the pin current source off.
// [RULE4] In noise detection, pin activity toggles the comparator output.
// [RULE5] A read-only status bit follows the source or sink phase.
// [RULE6] The oscillator clocks one of two timers; software selects which. The code clocks both at once when both are selected.
// [RULE7] Software sets the external clock select and clears the timer A source.
// [RULE8] Timer B source field 11 clocks timer B from the sense oscillator.
// [RULE9] Timer B is off with on at 0, free with gate off, gated otherwise.
// [RULE10] Software takes the time base from a timer other than the counting one.
// [RULE11] Timer A overflow toggling the timer B gate is the preferred time base.
// [RULE12] Software clears the counter at base start and reads it at base end.
// [RULE13] The enable bit connects the selected channel 0 to 15; otherwise none.
// [RULE14] The status bit is 1 while sourcing and 0 while sinking.
// [RULE15] The oscillator is synchronised before it advances any count.
`default_nettype none
package cap_sense_pkg;
  localparam int CHAN_W = 4;
  localparam int CHAN_N = 16;
  localparam int TA_W = 8;
  localparam int TB_W = 16;
  localparam int RANGE_W = 2;
  localparam int TB_SRC_W = 2;
  localparam logic [1:0] RANGE_OFF = 2'h0;
  localparam logic [1:0] RANGE_LOW = 2'h1;
  localparam logic [1:0] RANGE_MED = 2'h2;
  localparam logic [1:0] RANGE_HIGH = 2'h3;
  localparam logic [1:0] TB_SRC_SENSE = 2'h3;
  typedef enum logic [3:0] {
    CUR_OFF = 4'h1,
    CUR_LOW = 4'h2,
    CUR_MED = 4'h4,
    CUR_HIGH = 4'h8
  } current_e;
endpackage : cap_sense_pkg
`default_nettype wire

// ===== verilog/sense_edge_if.sv
// Interface carrying the synchronised oscillator edge between modules
`timescale 1ns/10ps
`default_nettype none
interface sense_edge_if;
  logic level;
  logic rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface : sense_edge_if
`default_nettype wire

// ===== verilog/sense_sync.sv
// Two-stage synchroniser and rising-edge detector for the sense oscillator
`timescale 1ns/10ps
`default_nettype none
module sense_sync (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic osc_i,
  sense_edge_if.src edge_o
);
  // ***************************************************
  // Synchroniser
  // ***************************************************
  // First stage feeds only the second; edge detect works on stages two and three
  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;
  always_comb begin
    next_meta = osc_i;
    next_sync = meta;
    next_prev = sync;
  end
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= next_meta; // [RULE15]
      sync <= next_sync; // [RULE15]
      prev <= next_prev;
    end
  end
  assign edge_o.level = sync;
  assign edge_o.rise = sync & ~prev; // [RULE15]
endmodule : sense_sync
`default_nettype wire

// ===== verilog/cap_sense_ctrl.sv
// Capacitive sense oscillator control, channel mux and timer clock routing
`timescale 1ns/10ps
`default_nettype none
module cap_sense_ctrl #(
  parameter int CHANNELS = cap_sense_pkg::CHAN_N
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic sense_module_enable_i,
  input wire logic reference_mode_sel_i,
  input wire logic [1:0] current_range_sel_i,
  input wire logic [3:0] sense_channel_sel_i,
  input wire logic timer_a_ext_clock_sel_i,
  input wire logic timer_a_clock_source_i,
  input wire logic [1:0] timer_b_clock_source_i,
  input wire logic timer_b_on_i,
  input wire logic timer_b_gate_enable_i,
  input wire logic timer_b_gate_i,
  input wire logic timer_a_clear_i,
  input wire logic timer_b_clear_i,
  input wire logic comparator_i,
  output logic osc_source_sink_flag_o,
  output logic variable_ref_o,
  output logic [3:0] current_sel_o,
  output logic pin_source_en_o,
  output logic [CHANNELS-1:0] channel_connect_o,
  output logic timer_a_inc_o,
  output logic timer_b_inc_o,
  output logic [7:0] timer_a_count_o,
  output logic [15:0] timer_b_count_o
);
  // Channel code is four bits wide, so more than sixteen lines cannot be addressed
  if (CHANNELS < 1 || CHANNELS > cap_sense_pkg::CHAN_N) begin : g_bad_channels
    $error("CHANNELS must be 1 to 16");
  end

  // ***************************************************
  // Decode helpers
  // ***************************************************
  function automatic cap_sense_pkg::current_e range_decode(input logic [1:0] rng);
    case (rng)
      cap_sense_pkg::RANGE_LOW: range_decode = cap_sense_pkg::CUR_LOW;
      cap_sense_pkg::RANGE_MED: range_decode = cap_sense_pkg::CUR_MED;
      cap_sense_pkg::RANGE_HIGH: range_decode = cap_sense_pkg::CUR_HIGH;
      default: range_decode = cap_sense_pkg::CUR_OFF;
    endcase
  endfunction : range_decode

  // ***************************************************
  // Oscillator synchronisation
  // ***************************************************
  // Comparator output is asynchronous to mclk; it is only counted once synchronised
  sense_edge_if osc_edge ();
  sense_sync u_sync (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .osc_i(comparator_i),
    .edge_o(osc_edge)
  );

  // ***************************************************
  // Oscillator configuration
  // ***************************************************
  logic noise_mode;
  logic osc_run;
  logic a_sel;
  logic b_sel;
  logic b_run;
  logic next_flag;
  logic next_varref;
  logic [3:0] next_cur;
  logic next_src_en;
  logic [CHANNELS-1:0] next_conn;
  logic next_a_inc;
  logic next_b_inc;
  logic [7:0] next_a_cnt;
  logic [15:0] next_b_cnt;

  always_comb begin
    noise_mode = reference_mode_sel_i && current_range_sel_i == cap_sense_pkg::RANGE_OFF; // [RULE3]
    // Fixed mode with range 00 stops the oscillator entirely
    osc_run = sense_module_enable_i &&
      (reference_mode_sel_i || current_range_sel_i != cap_sense_pkg::RANGE_OFF); // [RULE2]
    next_varref = reference_mode_sel_i; // [RULE1]
    next_cur = sense_module_enable_i ? range_decode(current_range_sel_i)
                                     : cap_sense_pkg::CUR_OFF; // [RULE2] [RULE3]
    // Noise mode keeps the sink path and comparator but drops the pin source
    next_src_en = osc_run && !noise_mode; // [RULE3]
    // Status follows comparator phase, also when noise drives the pin
    next_flag = osc_run ? osc_edge.level : 1'b0; // [RULE5] [RULE14] [RULE4]
    // Timer A takes the oscillator with external select set and its own source bit clear
    a_sel = timer_a_ext_clock_sel_i && !timer_a_clock_source_i; // [RULE6] [RULE7]
    b_sel = timer_b_clock_source_i == cap_sense_pkg::TB_SRC_SENSE; // [RULE8]
    b_run = timer_b_on_i && (!timer_b_gate_enable_i || timer_b_gate_i); // [RULE9]
    next_a_inc = osc_run && a_sel && osc_edge.rise; // [RULE6] [RULE15]
    next_b_inc = osc_run && b_sel && b_run && osc_edge.rise; // [RULE8] [RULE9]
    next_a_cnt = timer_a_clear_i ? 8'h00 : timer_a_count_o + {7'h00, next_a_inc}; // [RULE12]
    next_b_cnt = timer_b_clear_i ? 16'h0000 : timer_b_count_o + {15'h0000, next_b_inc};
  end

  // ***************************************************
  // Channel mux
  // ***************************************************
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_conn
      assign next_conn[ch] = sense_module_enable_i &&
        sense_channel_sel_i == 4'(ch); // [RULE13]
    end
  endgenerate

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      osc_source_sink_flag_o <= 1'b0;
      variable_ref_o <= 1'b0;
      current_sel_o <= cap_sense_pkg::CUR_OFF;
      pin_source_en_o <= 1'b0;
      channel_connect_o <= '0;
      timer_a_inc_o <= 1'b0;
      timer_b_inc_o <= 1'b0;
      timer_a_count_o <= 8'h00;
      timer_b_count_o <= 16'h0000;
    end else begin
      osc_source_sink_flag_o <= next_flag;
      variable_ref_o <= next_varref;
      current_sel_o <= next_cur;
      pin_source_en_o <= next_src_en;
      channel_connect_o <= next_conn;
      timer_a_inc_o <= next_a_inc;
      timer_b_inc_o <= next_b_inc;
      timer_a_count_o <= next_a_cnt;
      timer_b_count_o <= next_b_cnt;
    end
  end

  // ***************************************************
  // Assertions
  // ***************************************************
  property p_varref;
    @(posedge mclk_i) disable iff (!resetn_i)
      1'b1 |=> variable_ref_o == $past(reference_mode_sel_i);
  endproperty
  a_varref: assert property (p_varref) else $error("reference mode not followed"); // [RULE1]

  property p_fixed_off;
    @(posedge mclk_i) disable iff (!resetn_i)
      !reference_mode_sel_i && current_range_sel_i == cap_sense_pkg::RANGE_OFF |=>
        current_sel_o == cap_sense_pkg::CUR_OFF && !pin_source_en_o && !osc_source_sink_flag_o;
  endproperty
  a_fixed_off: assert property (p_fixed_off) else $error("fixed 00 not off"); // [RULE2]

  property p_high;
    @(posedge mclk_i) disable iff (!resetn_i)
      sense_module_enable_i && current_range_sel_i == cap_sense_pkg::RANGE_HIGH |=>
        current_sel_o == cap_sense_pkg::CUR_HIGH;
  endproperty
  a_high: assert property (p_high) else $error("range 11 not high"); // [RULE2]

  property p_noise;
    @(posedge mclk_i) disable iff (!resetn_i)
      sense_module_enable_i && reference_mode_sel_i &&
        current_range_sel_i == cap_sense_pkg::RANGE_OFF |=>
        !pin_source_en_o;
  endproperty
  a_noise: assert property (p_noise) else $error("noise mode left source on"); // [RULE3]

  property p_status;
    @(posedge mclk_i) disable iff (!resetn_i)
      $rose(comparator_i) && osc_run ##1 osc_run [*2] |=> osc_source_sink_flag_o;
  endproperty
  a_status: assert property (p_status) else $error("status not following phase"); // [RULE14]

  property p_b_gate;
    @(posedge mclk_i) disable iff (!resetn_i)
      !timer_b_on_i || (timer_b_gate_enable_i && !timer_b_gate_i) |=> !timer_b_inc_o;
  endproperty
  a_b_gate: assert property (p_b_gate) else $error("timer b counted while stopped"); // [RULE9]

  property p_b_src;
    @(posedge mclk_i) disable iff (!resetn_i)
      timer_b_clock_source_i != cap_sense_pkg::TB_SRC_SENSE |=> !timer_b_inc_o;
  endproperty
  a_b_src: assert property (p_b_src) else $error("timer b counted without sense source"); // [RULE8]

  property p_a_sel;
    @(posedge mclk_i) disable iff (!resetn_i)
      !(timer_a_ext_clock_sel_i && !timer_a_clock_source_i) |=> !timer_a_inc_o;
  endproperty
  a_a_sel: assert property (p_a_sel) else $error("timer a counted unselected"); // [RULE6]

  property p_chan;
    @(posedge mclk_i) disable iff (!resetn_i)
      !sense_module_enable_i |=> channel_connect_o == '0;
  endproperty
  a_chan: assert property (p_chan) else $error("channel connected while disabled"); // [RULE13]

  property p_single_edge;
    @(posedge mclk_i) disable iff (!resetn_i)
      timer_a_inc_o |=> !timer_a_inc_o;
  endproperty
  a_single_edge: assert property (p_single_edge) else $error("edge counted twice"); // [RULE15]

  property p_flag_idle;
    @(posedge mclk_i) disable iff (!resetn_i)
      !osc_run |=> !osc_source_sink_flag_o;
  endproperty
  a_flag_idle: assert property (p_flag_idle) else $error("status set while off"); // [RULE5]

  property p_source_on;
    @(posedge mclk_i) disable iff (!resetn_i)
      sense_module_enable_i && current_range_sel_i != cap_sense_pkg::RANGE_OFF |=>
        pin_source_en_o;
  endproperty
  a_source_on: assert property (p_source_on) else $error("pin source missing"); // [RULE2]

  // Count checked against its own past value, so a dropped or doubled pulse shows
  property p_a_count;
    @(posedge mclk_i) disable iff (!resetn_i)
      !timer_a_clear_i |=> timer_a_count_o == $past(timer_a_count_o) + 8'(timer_a_inc_o);
  endproperty
  a_a_count: assert property (p_a_count) else $error("timer a count wrong"); // [RULE6] [RULE15]

  property p_b_count;
    @(posedge mclk_i) disable iff (!resetn_i)
      !timer_b_clear_i |=> timer_b_count_o == $past(timer_b_count_o) + 16'(timer_b_inc_o);
  endproperty
  a_b_count: assert property (p_b_count) else $error("timer b count wrong"); // [RULE8] [RULE9]

  property p_a_clear;
    @(posedge mclk_i) disable iff (!resetn_i)
      timer_a_clear_i |=> timer_a_count_o == 8'h00;
  endproperty
  a_a_clear: assert property (p_a_clear) else $error("timer a not cleared"); // [RULE12]
endmodule : cap_sense_ctrl
`default_nettype wire

// ===== test/touch_pad_model.sv
// Touch pad model driving the oscillator comparator phase into the block
`timescale 1ns/10ps
`default_nettype none
module touch_pad_model (
  output logic osc_o
);
  initial osc_o = 1'b0;
  // A steady level stands for a stalled or switched off oscillator
  task automatic hold(input logic v);
    osc_o = v;
  endtask : hold
  // Free phase, half period kept above two clocks so the sync sees every edge
  task automatic burst(input int n, input int half_ns);
    repeat (n) begin
      #(half_ns) osc_o = 1'b1;
      #(half_ns) osc_o = 1'b0;
    end
  endtask : burst
endmodule : touch_pad_model
`default_nettype wire

// ===== test/capacitive_sense_oscillator_ctrl_tb_top.sv
// Self-checking testbench for the capacitive sense oscillator control block
`timescale 1ns/10ps
`default_nettype none
module capacitive_sense_oscillator_ctrl_tb_top;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic en = 0, rm = 0, axs = 0, acs = 0, bon = 0, bge = 0, bg = 0, aclr = 0, bclr = 0;
  logic [1:0] rng = 2'h0, bsrc = 2'h0;
  logic [3:0] ch = 4'h0;
  logic osc, flag, vref, srcen, ainc, binc;
  logic [3:0] cur;
  logic [15:0] conn, bcnt;
  logic [7:0] acnt;
  int n_fail = 0, checks = 0, seed = 4, na = 0, nb = 0, i;
  always #4 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    if (ainc === 1'b1) na++;
    if (binc === 1'b1) nb++;
  end
  touch_pad_model pad (.osc_o(osc));
  cap_sense_ctrl uut (.mclk_i(mclk_i), .resetn_i(resetn_i), .sense_module_enable_i(en),
    .reference_mode_sel_i(rm), .current_range_sel_i(rng), .sense_channel_sel_i(ch),
    .timer_a_ext_clock_sel_i(axs), .timer_a_clock_source_i(acs),
    .timer_b_clock_source_i(bsrc), .timer_b_on_i(bon), .timer_b_gate_enable_i(bge),
    .timer_b_gate_i(bg), .timer_a_clear_i(aclr), .timer_b_clear_i(bclr), .comparator_i(osc),
    .osc_source_sink_flag_o(flag), .variable_ref_o(vref), .current_sel_o(cur),
    .pin_source_en_o(srcen), .channel_connect_o(conn), .timer_a_inc_o(ainc),
    .timer_b_inc_o(binc), .timer_a_count_o(acnt), .timer_b_count_o(bcnt));
  function automatic logic [15:0] exp_conn(input logic e, input logic [3:0] c);
    return e ? 16'h1 << c : 16'h0;
  endfunction : exp_conn
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tick
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // Clear at base start, read at base end; the base is the burst, not the counting timer
  task automatic run(input logic [1:0] ta, input logic [1:0] src, input logic on, ge, g,
                     input int n);
    logic live;
    logic [15:0] ea, eb;
    live = en && (rm || rng != 2'h0);
    {axs, acs} = ta;
    bsrc = src;
    bon = on;
    bge = ge;
    bg = g;
    aclr = 1'b1;
    bclr = 1'b1;
    tick(1);
    aclr = 1'b0;
    bclr = 1'b0;
    na = 0;
    nb = 0;
    ea = (live && ta == 2'b10) ? 16'(n) : 16'h0;
    eb = (live && src == 2'h3 && on && (!ge || g)) ? 16'(n) : 16'h0;
    pad.burst(n, 17 + $unsigned($random(seed)) % 20);
    tick(6);
    chk({8'h0, acnt}, {8'h0, ea[7:0]}, "count a");
    chk(16'(na), ea, "pulses a");
    chk(bcnt, eb, "count b");
    chk(16'(nb), eb, "pulses b");
  endtask : run
  initial begin
    #400000;
    n_fail++;
    $display("[FAIL] %0t timeout", $time);
    give_verdict();
  end
  initial begin
    tick(5);
    chk(cur, 4'h1, "reset cur");
    chk({flag, vref, srcen, ainc, binc}, 16'h0, "reset flags");
    chk(conn | bcnt | acnt, 16'h0, "reset counts");
    tick(1);
    resetn_i = 1'b1;
    // ************
    // Configuration
    // ************
    for (i = 0; i < 48; i++) begin
      en = (i < 32) ? 1'b1 : 1'($random(seed));
      rm = i[3];
      rng = i[1:0];
      ch = 4'($random(seed));
      tick(2);
      chk(vref, rm, "vref");
      chk(cur, en ? 4'h1 << rng : 4'h1, "range");
      chk(srcen, en && rng != 2'h0, "source");
      chk(conn, exp_conn(en, ch), "channel");
    end
    $display("config test done");
    en = 1'b1;
    rm = 1'b0;
    rng = 2'h1;
    pad.hold(1'b1);
    tick(5);
    chk(flag, 1'b1, "sourcing");
    pad.hold(1'b0);
    tick(5);
    chk(flag, 1'b0, "sinking");
    pad.hold(1'b1);
    rng = 2'h0;
    tick(5);
    chk(flag, 1'b0, "osc off");
    rm = 1'b1;
    tick(5);
    chk(flag, 1'b1, "noise");
    pad.hold(1'b0);
    $display("status test done");
    // ************
    // Timer routing
    // ************
    rng = 2'h2;
    run(2'b10, 2'h0, 1, 0, 0, 260);
    run(2'b10, 2'h3, 1, 0, 0, 1 + $unsigned($random(seed)) % 40);
    run(2'b01, 2'h3, 1, 1, 0, 1 + $unsigned($random(seed)) % 40);
    run(2'b11, 2'h3, 1, 1, 1, 1 + $unsigned($random(seed)) % 40);
    run(2'b10, 2'h3, 0, 0, 0, 1 + $unsigned($random(seed)) % 40);
    run(2'b10, 2'h2, 1, 0, 0, 1 + $unsigned($random(seed)) % 40);
    rm = 1'b0;
    rng = 2'h0;
    run(2'b10, 2'h3, 1, 0, 0, 12);
    $display("timer test done");
    give_verdict();
  end
endmodule : capacitive_sense_oscillator_ctrl_tb_top
`default_nettype wire
